/* File: rtl/vcmd_pkg.sv */
// Shared constants, types and register map of the voltage code mode decoder.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
package vcmd_pkg;

  // ----------------------------------------------------------------------
  // Reference scale: one unit of a reference code is 12.5 mV.
  // ----------------------------------------------------------------------
  localparam int unsigned REF_W = 8;
  typedef logic [REF_W-1:0] vcmd_ref_t;

  localparam vcmd_ref_t REF_ZERO     = 8'h00;
  localparam vcmd_ref_t REF_STEP     = 8'h01;
  localparam vcmd_ref_t REF_1V550    = 8'h7c;
  localparam vcmd_ref_t PAR_LOW_BASE = 8'h5d;
  localparam logic [5:0] PAR_SPLIT   = 6'h20;
  localparam logic [6:0] SER_OFF_MIN = 7'h7c;

  localparam vcmd_ref_t REF_1V4 = 8'h70;
  localparam vcmd_ref_t REF_1V2 = 8'h60;
  localparam vcmd_ref_t REF_1V1 = 8'h58;
  localparam vcmd_ref_t REF_1V0 = 8'h50;
  localparam vcmd_ref_t REF_0V9 = 8'h48;
  localparam vcmd_ref_t REF_0V8 = 8'h40;

  // ----------------------------------------------------------------------
  // Register map and fields.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_REF    = 8'h0c;

  localparam int unsigned TICK_W        = 16;
  localparam logic [15:0] TICK_RESET    = 16'h0100;
  localparam int unsigned CMD_CODE_W    = 7;
  localparam int unsigned CMD_CORE_BIT  = 7;
  localparam int unsigned CMD_BRG_BIT   = 8;
  localparam int unsigned ST_MODE_BIT   = 0;
  localparam int unsigned ST_STATE_LSB  = 1;
  localparam int unsigned ST_PGOOD_BIT  = 3;
  localparam int unsigned ST_POK_BIT    = 4;
  localparam int unsigned ST_FIXED_BIT  = 5;
  localparam int unsigned ST_HOLD_LSB   = 8;
  localparam int unsigned REF_BRG_LSB   = 8;
  localparam int unsigned SYNC_STAGES   = 2;

  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along off, soft-start, run, ramp-down.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    VCMD_OFF  = 2'h0,
    VCMD_SOFT = 2'h1,
    VCMD_RUN  = 2'h3,
    VCMD_DOWN = 2'h2
  } vcmd_state_t;

  // Pin inputs that arrive from outside the clock domain.
  typedef struct packed {
    logic       enable;
    logic       mode_select_pin;
    logic       fixed_code_enable;
    logic       serial_clock;
    logic       serial_code_data;
    logic       host_power_ok;
    logic       core_in_reg;
    logic       bridge_in_reg;
    logic [5:0] parallel_code;
  } vcmd_pins_t;

endpackage

/* File: rtl/vcmd_sync.sv */
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is an independent level; no bus coherency is implied.
module vcmd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // One flop pair per bit; only the second flop is read outside.
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule // vcmd_sync

/* File: rtl/vcmd_ramp.sv */
// Reference stepper for one plane: moves one unit per tick period.
// Assumes the target and tick period come from the same clock domain.
module vcmd_ramp (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  input  wire vcmd_pkg::vcmd_ref_t         target_in,
  input  wire logic [vcmd_pkg::TICK_W-1:0] tick_in,
  output vcmd_pkg::vcmd_ref_t              ref_out,
  output logic                             at_target_out
);

  logic [vcmd_pkg::TICK_W-1:0] cnt_q;
  logic [vcmd_pkg::TICK_W-1:0] cnt_d;
  vcmd_pkg::vcmd_ref_t         ref_d;
  logic                        step;
  logic                        going_up;

  // ----------------------------------------------------------------------
  // Step decision.
  // ----------------------------------------------------------------------
  assign at_target_out = (ref_out == target_in);
  assign step          = !at_target_out && (cnt_q >= tick_in); // RQ20
  assign going_up      = (ref_out < target_in);
  assign cnt_d         = (at_target_out || step) ? '0 :
                         cnt_q + {{(vcmd_pkg::TICK_W-1){1'b0}}, 1'b1};
  assign ref_d         = !step   ? ref_out :
                         going_up ? ref_out + vcmd_pkg::REF_STEP :
                                    ref_out - vcmd_pkg::REF_STEP;

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q   <= '0;
      ref_out <= vcmd_pkg::REF_ZERO;
    end else begin
      cnt_q   <= cnt_d;
      ref_out <= ref_d; // RQ10
    end
  end

endmodule // vcmd_ramp

/* File: rtl/vcmd_top.sv */
// Digital front end of a dual-plane regulator: mode latch, code decode,
// soft-start sequencing, power-good and an APB register slave.
// Assumes pins are asynchronous to clock_in and APB is on clock_in.
//
// Contract
// RQ1: Enable low: planes off, mode select sampled.
// RQ2: Mode captured once on enable rise, held.
// RQ3: Low captures serial mode, high parallel mode.
// RQ4: Host holds mode select stable 1 us.
// RQ5: Parallel mode: bridge plane off, core only.
// RQ6: Six-bit parallel code maps to reference level.
// RQ7: Clock/data decoded per power-ok and fixed enable; the code decodes the straps by fixed enable alone.
// RQ8: Fixed enable low: start-up target table.
// RQ9: Enable rise latches start-up target in holding.
// RQ10: Soft-start steps reference up, both planes together.
// RQ11: Power-good after soft-start with planes regulated.
// RQ12: Enable fall: drop power-good, ramp to zero.
// RQ13: Fixed enable high: fixed target table.
// RQ14: Fixed mode re-decodes straps when they change.
// RQ15: Fixed mode soft-starts then asserts power-good.
// RQ16: After power-good and power-ok, accept commands.
// RQ17: Power-ok low: back to held target, ignore link.
// RQ18: Seven-bit command code, top four codes off.
// RQ19: All pin inputs pass two-flop synchronisers.
// RQ20: Stepper moves one unit per tick period.
module vcmd_top (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        enable_in,
  input  wire logic        mode_select_pin_in,
  input  wire logic [5:0]  parallel_code_in,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_code_data_in,
  input  wire logic        host_power_ok_in,
  input  wire logic        fixed_code_enable_in,
  input  wire logic        core_in_reg_in,
  input  wire logic        bridge_in_reg_in,
  output logic             core_enable_out,
  output logic             bridge_enable_out,
  output logic [7:0]       core_ref_out,
  output logic [7:0]       bridge_ref_out,
  output logic             planes_power_good_out,
  output logic             parallel_code_mode_out
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  vcmd_pkg::vcmd_pins_t         pins_raw;
  vcmd_pkg::vcmd_pins_t         pins_s;
  vcmd_pkg::vcmd_state_t        state_q;
  vcmd_pkg::vcmd_state_t        state_d;
  logic                         en_d_q;
  logic                         en_rise;
  logic                         en_fall_seen;
  logic                         mode_par_q;
  logic                         mode_par_d;
  vcmd_pkg::vcmd_ref_t          hold_q;
  vcmd_pkg::vcmd_ref_t          hold_d;
  logic [vcmd_pkg::TICK_W-1:0]  tick_q;
  logic [vcmd_pkg::TICK_W-1:0]  tick_d;
  logic [6:0]                   cmd_core_q;
  logic [6:0]                   cmd_brg_q;
  logic                         cmd_core_v_q;
  logic                         cmd_brg_v_q;
  logic                         cmd_ok;
  logic                         cmd_wr;
  logic                         cmd_core_hit;
  logic                         cmd_brg_hit;
  logic [6:0]                   cmd_code;
  vcmd_pkg::vcmd_ref_t          metal_ref;
  vcmd_pkg::vcmd_ref_t          fixed_ref;
  vcmd_pkg::vcmd_ref_t          startup_ref;
  vcmd_pkg::vcmd_ref_t          par_ref;
  vcmd_pkg::vcmd_ref_t          cmd_core_ref;
  vcmd_pkg::vcmd_ref_t          cmd_brg_ref;
  vcmd_pkg::vcmd_ref_t          ser_core_ref;
  vcmd_pkg::vcmd_ref_t          ser_brg_ref;
  vcmd_pkg::vcmd_ref_t          core_tgt;
  vcmd_pkg::vcmd_ref_t          brg_tgt;
  logic                         core_at;
  logic                         brg_at;
  logic                         planes_on;
  logic                         soft_done;
  logic                         refs_zero;
  logic                         apb_setup;
  logic                         apb_access;
  logic                         apb_wr;
  logic                         hit_ctrl;
  logic                         hit_status;
  logic                         hit_cmd;
  logic                         hit_ref;
  logic                         hit_any;
  logic [31:0]                  rd_word;
  logic [31:0]                  status_word;
  logic [31:0]                  ref_word;
  logic                         core_en_d;
  logic                         brg_en_d;
  logic                         pgood_d;

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  assign pins_raw = '{enable:            enable_in,
                      mode_select_pin:   mode_select_pin_in,
                      fixed_code_enable: fixed_code_enable_in,
                      serial_clock:      serial_clock_in,
                      serial_code_data:  serial_code_data_in,
                      host_power_ok:     host_power_ok_in,
                      core_in_reg:       core_in_reg_in,
                      bridge_in_reg:     bridge_in_reg_in,
                      parallel_code:     parallel_code_in};

  vcmd_sync #(
    .WIDTH ($bits(vcmd_pkg::vcmd_pins_t))
  ) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (pins_raw),
    .sync_out (pins_s)
  ); // RQ19

  // ----------------------------------------------------------------------
  // Enable edge and mode capture.
  // ----------------------------------------------------------------------
  assign en_rise      = pins_s.enable && !en_d_q;
  assign en_fall_seen = !pins_s.enable;

  // While off the mode follows the pin; the edge freezes the last sample.
  assign mode_par_d = (state_q == vcmd_pkg::VCMD_OFF) ?
                      pins_s.mode_select_pin : mode_par_q; // RQ1 RQ2 RQ3

  // ----------------------------------------------------------------------
  // Start-up target decode from the clock/data straps.
  // ----------------------------------------------------------------------
  always_comb begin
    unique case ({pins_s.serial_clock, pins_s.serial_code_data})
      2'b00:   metal_ref = vcmd_pkg::REF_1V1;
      2'b01:   metal_ref = vcmd_pkg::REF_1V0;
      2'b10:   metal_ref = vcmd_pkg::REF_0V9;
      2'b11:   metal_ref = vcmd_pkg::REF_0V8;
      default: metal_ref = vcmd_pkg::REF_ZERO;
    endcase
  end // RQ8

  always_comb begin
    unique case ({pins_s.serial_clock, pins_s.serial_code_data})
      2'b00:   fixed_ref = vcmd_pkg::REF_1V4;
      2'b01:   fixed_ref = vcmd_pkg::REF_1V2;
      2'b10:   fixed_ref = vcmd_pkg::REF_1V0;
      2'b11:   fixed_ref = vcmd_pkg::REF_0V8;
      default: fixed_ref = vcmd_pkg::REF_ZERO;
    endcase
  end // RQ13

  assign startup_ref = pins_s.fixed_code_enable ? fixed_ref : metal_ref; // RQ7
  assign hold_d      = en_rise && (state_q == vcmd_pkg::VCMD_OFF) ?
                       startup_ref : hold_q; // RQ9

  // ----------------------------------------------------------------------
  // Parallel code decode: 25 mV steps, then 12.5 mV steps.
  // ----------------------------------------------------------------------
  assign par_ref =
    (pins_s.parallel_code < vcmd_pkg::PAR_SPLIT) ?
    vcmd_pkg::REF_1V550 - {2'b00, pins_s.parallel_code[4:0], 1'b0} :
    vcmd_pkg::PAR_LOW_BASE - {2'b00, pins_s.parallel_code}; // RQ6

  // ----------------------------------------------------------------------
  // Set-voltage commands, 12.5 mV per code, top codes turn the plane off.
  // ----------------------------------------------------------------------
  assign cmd_code     = pwdata_in[vcmd_pkg::CMD_CODE_W-1:0];
  assign cmd_core_hit = pwdata_in[vcmd_pkg::CMD_CORE_BIT];
  assign cmd_brg_hit  = pwdata_in[vcmd_pkg::CMD_BRG_BIT];
  assign cmd_ok       = (state_q == vcmd_pkg::VCMD_RUN) && !mode_par_q &&
                        !pins_s.fixed_code_enable &&
                        pins_s.host_power_ok; // RQ16 RQ17
  assign cmd_wr       = apb_wr && hit_cmd && cmd_ok;

  assign cmd_core_ref = (cmd_core_q >= vcmd_pkg::SER_OFF_MIN) ?
                        vcmd_pkg::REF_ZERO :
                        vcmd_pkg::REF_1V550 - {1'b0, cmd_core_q}; // RQ18
  assign cmd_brg_ref  = (cmd_brg_q >= vcmd_pkg::SER_OFF_MIN) ?
                        vcmd_pkg::REF_ZERO :
                        vcmd_pkg::REF_1V550 - {1'b0, cmd_brg_q}; // RQ18

  // ----------------------------------------------------------------------
  // Target selection for both planes.
  // ----------------------------------------------------------------------
  // Fixed mode follows the live straps so a moved jumper is re-decoded.
  assign ser_core_ref = pins_s.fixed_code_enable ? fixed_ref :
                        cmd_core_v_q ? cmd_core_ref : hold_q; // RQ14 RQ17
  assign ser_brg_ref  = pins_s.fixed_code_enable ? fixed_ref :
                        cmd_brg_v_q ? cmd_brg_ref : hold_q; // RQ14 RQ17

  assign planes_on = (state_q == vcmd_pkg::VCMD_SOFT) ||
                     (state_q == vcmd_pkg::VCMD_RUN);
  assign core_tgt  = !planes_on ? vcmd_pkg::REF_ZERO :
                     mode_par_q ? par_ref : ser_core_ref; // RQ12 RQ15
  assign brg_tgt   = (!planes_on || mode_par_q) ?
                     vcmd_pkg::REF_ZERO : ser_brg_ref; // RQ5 RQ12

  vcmd_ramp u_core_ramp (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .target_in     (core_tgt),
    .tick_in       (tick_q),
    .ref_out       (core_ref_out),
    .at_target_out (core_at)
  ); // RQ10

  vcmd_ramp u_brg_ramp (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .target_in     (brg_tgt),
    .tick_in       (tick_q),
    .ref_out       (bridge_ref_out),
    .at_target_out (brg_at)
  ); // RQ10

  // ----------------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------------
  assign soft_done = core_at && brg_at && pins_s.core_in_reg &&
                     (mode_par_q || pins_s.bridge_in_reg); // RQ11
  assign refs_zero = (core_ref_out == vcmd_pkg::REF_ZERO) &&
                     (bridge_ref_out == vcmd_pkg::REF_ZERO);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      vcmd_pkg::VCMD_OFF: begin
        if (en_rise) begin
          state_d = vcmd_pkg::VCMD_SOFT;
        end
      end
      vcmd_pkg::VCMD_SOFT: begin
        if (en_fall_seen) begin
          state_d = vcmd_pkg::VCMD_DOWN;
        end else if (soft_done) begin
          state_d = vcmd_pkg::VCMD_RUN;
        end
      end
      vcmd_pkg::VCMD_RUN: begin
        if (en_fall_seen) begin
          state_d = vcmd_pkg::VCMD_DOWN; // RQ12
        end
      end
      vcmd_pkg::VCMD_DOWN: begin
        if (refs_zero) begin
          state_d = vcmd_pkg::VCMD_OFF;
        end
      end
    endcase
  end

  assign pgood_d   = (state_d == vcmd_pkg::VCMD_RUN); // RQ11 RQ12 RQ15
  assign core_en_d = (state_d != vcmd_pkg::VCMD_OFF); // RQ1
  assign brg_en_d  = (state_d != vcmd_pkg::VCMD_OFF) && !mode_par_d; // RQ5

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q                <= vcmd_pkg::VCMD_OFF;
      en_d_q                 <= 1'b0;
      mode_par_q             <= 1'b0;
      hold_q                 <= vcmd_pkg::REF_ZERO;
      planes_power_good_out  <= 1'b0;
      core_enable_out        <= 1'b0;
      bridge_enable_out      <= 1'b0;
      parallel_code_mode_out <= 1'b0;
    end else begin
      state_q                <= state_d;
      en_d_q                 <= pins_s.enable;
      mode_par_q             <= mode_par_d;
      hold_q                 <= hold_d;
      planes_power_good_out  <= pgood_d;
      core_enable_out        <= core_en_d;
      bridge_enable_out      <= brg_en_d;
      parallel_code_mode_out <= mode_par_d;
    end
  end

  // ----------------------------------------------------------------------
  // Command holding registers.
  // ----------------------------------------------------------------------
  // Dropping power-ok or leaving run forgets every command received.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_core_q   <= '0;
      cmd_brg_q    <= '0;
      cmd_core_v_q <= 1'b0;
      cmd_brg_v_q  <= 1'b0;
    end else if (!cmd_ok) begin
      cmd_core_v_q <= 1'b0; // RQ17
      cmd_brg_v_q  <= 1'b0; // RQ17
    end else if (cmd_wr) begin
      if (cmd_core_hit) begin
        cmd_core_q   <= cmd_code;
        cmd_core_v_q <= 1'b1; // RQ16
      end
      if (cmd_brg_hit) begin
        cmd_brg_q   <= cmd_code;
        cmd_brg_v_q <= 1'b1; // RQ16
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: answers in the first access cycle.
  // ----------------------------------------------------------------------
  assign apb_setup  = psel_in && !penable_in;
  assign apb_access = psel_in && penable_in && pready_out;
  assign apb_wr     = apb_access && pwrite_in;
  assign hit_ctrl   = (paddr_in == vcmd_pkg::ADDR_CTRL);
  assign hit_status = (paddr_in == vcmd_pkg::ADDR_STATUS);
  assign hit_cmd    = (paddr_in == vcmd_pkg::ADDR_CMD);
  assign hit_ref    = (paddr_in == vcmd_pkg::ADDR_REF);
  assign hit_any    = hit_ctrl || hit_status || hit_cmd || hit_ref;

  always_comb begin
    status_word = '0;
    status_word[vcmd_pkg::ST_MODE_BIT] = mode_par_q;
    status_word[vcmd_pkg::ST_STATE_LSB +: 2] = state_q;
    status_word[vcmd_pkg::ST_PGOOD_BIT] = planes_power_good_out;
    status_word[vcmd_pkg::ST_POK_BIT] = pins_s.host_power_ok;
    status_word[vcmd_pkg::ST_FIXED_BIT] = pins_s.fixed_code_enable;
    status_word[vcmd_pkg::ST_HOLD_LSB +: vcmd_pkg::REF_W] = hold_q;
  end

  always_comb begin
    ref_word = '0;
    ref_word[vcmd_pkg::REF_W-1:0] = core_ref_out;
    ref_word[vcmd_pkg::REF_BRG_LSB +: vcmd_pkg::REF_W] = bridge_ref_out;
  end

  assign rd_word = hit_ctrl   ? {{(32-vcmd_pkg::TICK_W){1'b0}}, tick_q} :
                   hit_status ? status_word :
                   hit_ref    ? ref_word : '0;

  assign tick_d = (apb_wr && hit_ctrl) ?
                  pwdata_in[vcmd_pkg::TICK_W-1:0] : tick_q; // RQ20

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
      tick_q      <= vcmd_pkg::TICK_RESET;
    end else begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup && !hit_any;
      prdata_out  <= (apb_setup && !pwrite_in) ? rd_word : '0;
      tick_q      <= tick_d;
    end
  end

endmodule // vcmd_top

/* File: verif/vcmd_assertions.sv */
// Port checks for the voltage code mode decoder top.
// Assumes one clock domain and an active-low asynchronous reset.
module vcmd_assertions (
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic       enable_in,
  input wire logic       mode_select_pin_in,
  input wire logic       core_enable_out,
  input wire logic       bridge_enable_out,
  input wire logic [7:0] core_ref_out,
  input wire logic       planes_power_good_out,
  input wire logic       parallel_code_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  property p_off_hold;
    (!enable_in) [*6] |-> core_ref_out <= $past(core_ref_out) && !$rose(core_enable_out);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("ref rose while disabled");
  property p_pg_drop;
    (!enable_in) [*4] |-> !planes_power_good_out;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("power good kept");
  property p_mode_hold;
    core_enable_out && $past(core_enable_out) |-> $stable(parallel_code_mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_mode_pick;
    $rose(core_enable_out) |-> parallel_code_mode_out == $past(mode_select_pin_in, 3);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("wrong mode");
  property p_par_bridge;
    parallel_code_mode_out |-> !bridge_enable_out;
  endproperty
  a_par_bridge: assert property (p_par_bridge) else $error("bridge on");
  property p_step;
    !planes_power_good_out |-> (core_ref_out - $past(core_ref_out) + 8'h01) <= 8'h02;
  endproperty
  a_step: assert property (p_step) else $error("ref jumped");
  property p_pg_rise;
    $rose(planes_power_good_out) |-> core_enable_out && $stable(core_ref_out);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("early power good");
  property p_sync;
    $rose(enable_in) && !core_enable_out |=> (!core_enable_out) [*2];
  endproperty
  a_sync: assert property (p_sync) else $error("enable not delayed");
  c_ser: cover property ($rose(planes_power_good_out) && !parallel_code_mode_out);
  c_par: cover property ($rose(planes_power_good_out) && parallel_code_mode_out);
  c_off: cover property ($fell(core_enable_out));
endmodule // vcmd_assertions

/* File: verif/vcmd_host.sv */
// Host model: drives enable, mode select and the regulation flags.
// Assumes the bench asks for enable and mode; mode moves only while off.
module vcmd_host (
  input  wire logic clock_in,
  input  wire logic want_en_in,
  input  wire logic want_mode_in,
  output logic      enable_out,
  output logic      mode_out,
  output logic      in_reg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int stable_q = 0;
  initial {enable_out, mode_out} = 2'h0;
  // Comparators report regulation whenever the host drives enable high, in either mode.
  assign in_reg_out = enable_out;
  always @(posedge clock_in) begin
    if (!enable_out && want_mode_in !== mode_out) begin
      mode_out <= want_mode_in;
      stable_q <= 0;
    end else if (stable_q < 200) begin
      stable_q <= stable_q + 1;
    end
    enable_out <= want_en_in &&
                  (enable_out || (stable_q >= 130 && want_mode_in === mode_out));
  end
endmodule // vcmd_host

/* File: verif/vcmd_bench.sv */
// Self-checking bench for the voltage code mode decoder top.
// Assumes the host model drives enable and mode select.
module vcmd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, err;
  logic [7:0]  paddr = '0, core_ref, brg_ref;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, en, mode, inreg, core_en, brg_en, pgood, pmode;
  logic [5:0]  pcode = '0;
  logic        sclk = '0, sdat = '0, pok = '0, fix = '0, want_en = '0, want_mode = '0;
  int          errors = 0, compares = 0, seed = 77, c;
  int          pc[4] = '{0, 31, 32, 63};
  vcmd_top u_dut (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .enable_in(en), .mode_select_pin_in(mode),
    .parallel_code_in(pcode), .serial_clock_in(sclk), .serial_code_data_in(sdat),
    .host_power_ok_in(pok), .fixed_code_enable_in(fix), .core_in_reg_in(inreg),
    .bridge_in_reg_in(inreg), .core_enable_out(core_en), .bridge_enable_out(brg_en),
    .core_ref_out(core_ref), .bridge_ref_out(brg_ref), .planes_power_good_out(pgood),
    .parallel_code_mode_out(pmode));
  vcmd_host u_host (.clock_in(clk), .want_en_in(want_en), .want_mode_in(want_mode),
    .enable_out(en), .mode_out(mode), .in_reg_out(inreg));
  initial forever #4 clk = ~clk;
  initial begin
    #400000;
    errors++;
    summarize;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic start(input logic m, input int exp);
    int n = 0;
    want_mode <= m;
    want_en <= 1'h1;
    while (pgood !== 1'h1 && n++ < 3000) @(posedge clk);
    chk(core_ref, exp);
    chk(brg_ref, m ? 0 : exp);
    chk({pgood, brg_en, pmode}, {1'b1, !m, m});
  endtask
  task automatic stop;
    int n = 0;
    want_en <= 1'h0;
    repeat (6) @(posedge clk);
    chk(pgood, 32'h0);
    while (core_en !== 1'h0 && n++ < 3000) @(posedge clk);
    chk({core_en, core_ref, brg_ref}, 32'h0);
  endtask
  task summarize;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, vcmd_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h100);
    apb(1'h1, vcmd_pkg::ADDR_CTRL, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("done: registers");
    for (int i = 0; i < 8; i++) begin
      {fix, sclk, sdat} <= i[2:0];
      repeat (4) @(posedge clk);
      c = i < 4 ? 88 - 8 * i : 112 - 16 * (i - 4);
      start(1'h0, c);
      apb(1'h0, vcmd_pkg::ADDR_STATUS, 32'h0);
      chk(rd[15:8], c);
      stop;
    end
    $display("done: straps");
    for (int i = 0; i < 8; i++) begin
      c = i < 4 ? pc[i] : $random(seed) & 63;
      pcode <= c[5:0];
      start(1'h1, c < 32 ? 124 - 2 * c : 93 - c);
      stop;
    end
    $display("done: parallel");
    {fix, sclk, sdat} <= 3'h0;
    repeat (4) @(posedge clk);
    start(1'h0, 88);
    pok <= 1'h1;
    repeat (4) @(posedge clk);
    c = $unsigned($random(seed)) % 124;
    apb(1'h1, vcmd_pkg::ADDR_CMD, {23'h0, 2'h3, c[6:0]});
    repeat (300) @(posedge clk);
    chk({core_ref, brg_ref}, {8'(124 - c), 8'(124 - c)});
    apb(1'h1, vcmd_pkg::ADDR_CMD, 32'hfc);
    repeat (300) @(posedge clk);
    chk({core_ref, pgood}, 32'h1);
    pok <= 1'h0;
    repeat (300) @(posedge clk);
    chk({core_ref, brg_ref}, 32'h5858);
    stop;
    $display("done: commands");
    {fix, sclk, sdat} <= 3'h7;
    repeat (4) @(posedge clk);
    start(1'h0, 64);
    {sclk, sdat} <= 2'h0;
    repeat (300) @(posedge clk);
    chk(core_ref, 112);
    stop;
    $display("done: fixed");
    summarize;
  end
endmodule // vcmd_bench
bind vcmd_top vcmd_assertions u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .enable_in(enable_in), .mode_select_pin_in(mode_select_pin_in),
  .core_enable_out(core_enable_out), .bridge_enable_out(bridge_enable_out),
  .core_ref_out(core_ref_out), .planes_power_good_out(planes_power_good_out),
  .parallel_code_mode_out(parallel_code_mode_out));
